// *** rtl/memory_map_pkg.sv ***
// Constants and carrier types for the memory map decoder.
// Assumes a single 50 MHz clock domain and a 20-bit processor address.
package memory_map_pkg;
    // ************************************************************
    // Address spaces
    // ************************************************************
    localparam int MEM_ADDR_W = 20; // 1 Mbyte memory space
    localparam int IO_ADDR_W = 16; // 64 kbyte I/O space
    localparam int EPROM_KB_W = 8; // Window size in 1 kbyte units
    localparam int KB_SHIFT = 10; // One kbyte granule
    localparam logic [7:0] EPROM_MIN_KB = 8'h01; // Smallest window, 1 kbyte
    localparam logic [7:0] EPROM_MAX_KB = 8'hFF; // Largest window allowed
    localparam logic [7:0] EPROM_RESET_KB = 8'h01; // Window after reset
    localparam int PAIRS = 4; // RAM pairs fitted at most
    localparam logic [1:0] WAIT_RESET = 2'h3; // Safe EPROM waits at reset

    // ************************************************************
    // Enumerations
    // ************************************************************
    // RAM device size strap
    typedef enum logic [1:0] {
        RAM_8K = 2'b00,
        RAM_32K = 2'b01,
        RAM_128K = 2'b10
    } ram_size_t;

    // EPROM device size strap
    typedef enum logic [1:0] {
        ROM_16K = 2'b00,
        ROM_32K = 2'b01,
        ROM_64K = 2'b10,
        ROM_128K = 2'b11
    } rom_size_t;

    // Access cycle state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10
    } cycle_state_t;

    // ************************************************************
    // Carriers
    // ************************************************************
    // One processor bus request
    typedef struct packed {
        logic [MEM_ADDR_W-1:0] addr;
        logic is_io;
        logic rd;
        logic wr;
        logic bhe_n;
    } cpu_req_t;

    // Strobes toward memory and peripherals
    typedef struct packed {
        logic mem_rd;
        logic mem_wr;
        logic io_rd;
        logic io_wr;
    } strobes_t;

    // Selects toward memory devices
    typedef struct packed {
        logic rom_cs;
        logic [PAIRS-1:0] ram_cs;
        logic wr_lo;
        logic wr_hi;
    } mem_sel_t;
endpackage : memory_map_pkg

// *** rtl/eprom_window.sv ***
// EPROM window comparator and the RAM pair picker.
// Assumes the size value is already held in a register by the caller.
`timescale 1ns/1ns
`default_nettype none
module eprom_window (
    input wire logic [memory_map_pkg::MEM_ADDR_W-1:0] addr,
    input wire logic [memory_map_pkg::EPROM_KB_W-1:0] size_kb,
    input wire memory_map_pkg::ram_size_t ram_size,
    output logic in_rom,
    output logic [memory_map_pkg::PAIRS-1:0] pair_sel
);
    import memory_map_pkg::*;

    // ************************************************************
    // Window compare
    // ************************************************************
    // Offset from the top of the space, in kbyte units
    wire logic [MEM_ADDR_W-KB_SHIFT-1:0] down_kb;
    assign down_kb = ~addr[MEM_ADDR_W-1:KB_SHIFT];
    // Inside when fewer kbytes from the top than the window size
    assign in_rom = ({2'b00, size_kb} > down_kb);

    // ************************************************************
    // Pair select
    // ************************************************************
    // Pair index sits just above the span of one pair, which is twice
    // the device size because the two byte lanes share a word address
    wire logic [1:0] idx;
    wire logic fits;
    assign idx = (ram_size == RAM_8K) ? addr[15:14] :
                 (ram_size == RAM_32K) ? addr[17:16] :
                 addr[19:18];
    // Upper bits beyond four pairs must be zero; 128K pairs fill all
    assign fits = (ram_size == RAM_8K) ? (addr[19:16] == 4'h0) :
                  (ram_size == RAM_32K) ? (addr[19:18] == 2'h0) :
                  1'b1;
    // One-hot, only outside the window
    assign pair_sel = (fits && !in_rom) ? 4'(4'h1 << idx) : 4'h0;
endmodule : eprom_window
`default_nettype wire

// *** rtl/memory_map_decoder.sv ***
// Top of the memory and I/O decoder for the packet switch board.
// Assumes a processor bus synchronous to clock, with one request at a time
// presented as a level until ready is seen.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Decode 1 Mbyte memory, 64 kbyte I/O
// - Four strobes: mem/io read and write
// - I/O write strobe one stage late
// - EPROM sits at top of memory
// - Software size, minimum one kbyte
// - Size changes at run time
// - Zero to three EPROM wait states
// - Two EPROMs: low and high byte
// - EPROM devices 16K to 128K by 8
// - Four RAM pairs, three device sizes
// - RAM size picks one pair
// - No RAM select inside EPROM window
// - Byte writes strobe one lane only
// - Eight 128K RAMs fill the space
module memory_map_decoder #(
    parameter int WAIT_MAX = 3 // Most EPROM waits
) (
    input wire logic clock,
    input wire logic reset,
    input wire memory_map_pkg::cpu_req_t req,
    input wire memory_map_pkg::ram_size_t ram_size,
    input wire memory_map_pkg::rom_size_t rom_size,
    input wire logic cfg_we,
    input wire logic [memory_map_pkg::EPROM_KB_W-1:0] cfg_size_kb,
    input wire logic [1:0] cfg_waits,
    output memory_map_pkg::strobes_t strobes,
    output memory_map_pkg::mem_sel_t sel,
    output logic [16:0] rom_addr,
    output logic [memory_map_pkg::IO_ADDR_W-1:0] io_addr,
    output logic [memory_map_pkg::EPROM_KB_W-1:0] size_kb,
    output logic [1:0] waits,
    output logic ready
);
    import memory_map_pkg::*;

    // Refuse a wait range the two-bit counter cannot hold
    if (WAIT_MAX != 3) begin : g_check
        $error("WAIT_MAX must be 3");
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    logic [EPROM_KB_W-1:0] size_reg; // Window size, kbytes
    logic [1:0] waits_reg; // EPROM wait states
    wire logic [EPROM_KB_W-1:0] size_clamp; // Floor of one kbyte
    assign size_clamp = (cfg_size_kb < EPROM_MIN_KB) ? EPROM_MIN_KB :
                        cfg_size_kb;

    // Software writes take effect on the next cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            size_reg <= EPROM_RESET_KB;
            waits_reg <= WAIT_RESET;
        end else if (cfg_we) begin
            size_reg <= size_clamp;
            waits_reg <= cfg_waits;
        end
    end
    assign size_kb = size_reg;
    assign waits = waits_reg;

    // ************************************************************
    // Address decode
    // ************************************************************
    wire logic in_rom; // Address in EPROM window
    wire logic [PAIRS-1:0] pair_sel; // Selected RAM pair
    eprom_window u_window (
        .addr(req.addr),
        .size_kb(size_reg),
        .ram_size(ram_size),
        .in_rom(in_rom),
        .pair_sel(pair_sel)
    );

    // Memory and I/O spaces kept apart by the request type
    wire logic mem_cyc;
    wire logic io_cyc;
    wire logic active;
    assign mem_cyc = !req.is_io && (req.rd || req.wr);
    assign io_cyc = req.is_io && (req.rd || req.wr);
    assign active = mem_cyc || io_cyc;

    // Lanes: A0 low selects low byte, bhe_n low selects high byte
    wire logic lane_lo;
    wire logic lane_hi;
    assign lane_lo = !req.addr[0];
    assign lane_hi = !req.bhe_n;

    // EPROM device mask: word address bits beyond the part are dropped
    wire logic [16:0] rom_mask;
    // One address bit per doubling: 14 bits for 16K up to 17 for 128K
    assign rom_mask = (rom_size == ROM_16K) ? 17'h03FFF :
                      (rom_size == ROM_32K) ? 17'h07FFF :
                      (rom_size == ROM_64K) ? 17'h0FFFF :
                      17'h1FFFF;
    // Word address shared by both byte-wide parts
    wire logic [16:0] rom_word;
    assign rom_word = req.addr[17:1] & rom_mask;

    // ************************************************************
    // Cycle sequencer
    // ************************************************************
    cycle_state_t state_reg;
    cycle_state_t state_next;
    logic [1:0] count_reg; // Waits left
    logic [1:0] count_next;
    wire logic rom_cyc; // EPROM access, read or write, needs waits
    assign rom_cyc = mem_cyc && in_rom;

    // Idle takes the request; EPROM reads and writes wait the programmed count
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            ST_IDLE: begin
                if (active) begin
                    if (rom_cyc && waits_reg != 2'h0) begin
                        state_next = ST_WAIT;
                        count_next = waits_reg;
                    end else begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_WAIT: begin
                if (count_reg == 2'h1) begin
                    state_next = ST_DONE;
                end
                count_next = count_reg - 2'h1;
            end
            ST_DONE: begin
                // Back to idle so the next request is seen fresh
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Short state update
    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            count_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // Handshake straight from state
    assign ready = (state_reg == ST_DONE);

    // ************************************************************
    // Strobe generation
    // ************************************************************
    wire logic in_cycle; // Request held and not yet finished
    assign in_cycle = active && (state_reg != ST_IDLE);
    wire logic io_wr_early; // Raw I/O write, before delay stage
    assign io_wr_early = io_cyc && req.wr && (state_reg != ST_IDLE);

    strobes_t strobes_reg;
    strobes_t strobes_next;
    mem_sel_t sel_reg;
    mem_sel_t sel_next;
    logic io_wr_stage; // Delay stage for I/O write
    // Next strobe values; the I/O write takes the delayed copy
    always_comb begin
        strobes_next.mem_rd = in_cycle && mem_cyc && req.rd;
        strobes_next.mem_wr = in_cycle && mem_cyc && req.wr;
        strobes_next.io_rd = in_cycle && io_cyc && req.rd;
        // Stage copy lands one cycle after a plain strobe would, so
        // peripherals see settled data before the write edge
        strobes_next.io_wr = io_wr_stage;
        sel_next.rom_cs = in_cycle && rom_cyc && req.rd;
        sel_next.ram_cs = (in_cycle && mem_cyc) ? pair_sel : 4'h0;
        // Only the addressed lane gets a write; EPROM never written
        sel_next.wr_lo = in_cycle && mem_cyc && req.wr && !in_rom &&
                         lane_lo;
        sel_next.wr_hi = in_cycle && mem_cyc && req.wr && !in_rom &&
                         lane_hi;
    end

    // Outputs from flip-flops; addresses held for the cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            strobes_reg <= '0;
            sel_reg <= '0;
            io_wr_stage <= 1'b0;
            rom_addr <= 17'h00000;
            io_addr <= 16'h0000;
        end else begin
            strobes_reg <= strobes_next;
            sel_reg <= sel_next;
            io_wr_stage <= io_wr_early;
            rom_addr <= rom_word;
            io_addr <= req.addr[IO_ADDR_W-1:0];
        end
    end
    assign strobes = strobes_reg;
    assign sel = sel_reg;
endmodule : memory_map_decoder
`default_nettype wire

// *** sim/memory_map_sva.sv ***
// Port checker for the memory map decoder.
// Assumes one clock domain and a synchronous high reset.
`timescale 1ns/1ns
`default_nettype none
module memory_map_sva (
    input wire logic clock,
    input wire logic reset,
    input wire memory_map_pkg::cpu_req_t req,
    input wire memory_map_pkg::strobes_t strobes,
    input wire memory_map_pkg::mem_sel_t sel,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_size_kb,
    input wire logic [1:0] cfg_waits,
    input wire logic [7:0] size_kb,
    input wire logic [1:0] waits,
    input wire logic ready
);
    import memory_map_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [1:0] wc_reg; // Age of an EPROM cycle
    wire logic rom_busy = sel.rom_cs & (strobes.mem_rd | strobes.mem_wr);
    wire logic plain = strobes.mem_rd | strobes.mem_wr | strobes.io_rd;
    // Age restarts at ready so a following cycle never inherits it
    always_ff @(posedge clock) begin
        if (reset || ready || !rom_busy)
            wc_reg <= 2'h0;
        else
            wc_reg <= wc_reg + 2'h1;
    end
    a_one_strobe: assert property ($onehot0(strobes))
        else $error("strobes overlap");
    a_one_pair: assert property ($onehot0(sel.ram_cs))
        else $error("several RAM pairs enabled");
    a_rom_masks_ram: assert property (sel.rom_cs |-> !sel.ram_cs)
        else $error("RAM enabled inside EPROM window");
    a_rom_no_lane: assert property (sel.rom_cs
        |-> !sel.wr_lo && !sel.wr_hi)
        else $error("write lane inside EPROM window");
    // RAM and I/O read strobes land the cycle after ready; I/O write one later still
    a_iowr_late: assert property (ready && req.is_io && req.wr
        |=> !strobes.io_wr ##1 strobes.io_wr)
        else $error("io write not late");
    // A RAM or I/O read strobe always follows a prompt ready
    a_plain_ready: assert property ($rose(plain)
        && (strobes.io_rd || |sel.ram_cs) |-> $past(ready))
        else $error("wait state outside EPROM");
    // The age counter has seen one cycle less than the wait count
    a_rom_waits: assert property (ready && sel.rom_cs
        |-> 2'(wc_reg + 2'h1) == waits)
        else $error("EPROM wait count wrong");
    // Lanes follow the request that was held at the ready edge
    a_lane_steer: assert property (strobes.mem_wr && |sel.ram_cs
        |-> sel.wr_lo == !$past(req.addr[0])
        && sel.wr_hi == !$past(req.bhe_n))
        else $error("write lane steering wrong");
    a_size_floor: assert property (size_kb >= EPROM_MIN_KB)
        else $error("window below one kbyte");
    a_cfg_load: assert property (cfg_we |=> waits == $past(cfg_waits)
        && size_kb == ($past(cfg_size_kb) == 8'h00 ? 8'h01
        : $past(cfg_size_kb)))
        else $error("setting not loaded");
    c_rom_slow: cover property (ready && sel.rom_cs && waits == 2'h3);
    c_hi_write: cover property (sel.wr_hi && !sel.wr_lo);
    c_io_write: cover property ($rose(strobes.io_wr));
endmodule : memory_map_sva
bind memory_map_decoder memory_map_sva i_sva (.clock, .reset, .req, .strobes,
    .sel, .cfg_we, .cfg_size_kb, .cfg_waits, .size_kb, .waits, .ready);
`default_nettype wire

// *** sim/ram_pair_model.sv ***
// Far side model: RAM pairs that count write cycles per byte lane.
// Assumes selects stand for the whole write strobe.
`timescale 1ns/1ns
`default_nettype none
module ram_pair_model (
    input wire logic clock,
    input wire memory_map_pkg::strobes_t strobes,
    input wire memory_map_pkg::mem_sel_t sel,
    output logic [7:0] lo_hits,
    output logic [7:0] hi_hits
);
    import memory_map_pkg::*;
    logic wr_reg; // Write strobe a cycle ago
    initial begin
        lo_hits = 8'h00;
        hi_hits = 8'h00;
        wr_reg = 1'b0;
    end
    // A device latches only on its own strobe; the other lane keeps data
    always @(posedge clock) begin
        wr_reg <= strobes.mem_wr;
        if (strobes.mem_wr && !wr_reg && |sel.ram_cs) begin
            lo_hits <= lo_hits + {7'h00, sel.wr_lo};
            hi_hits <= hi_hits + {7'h00, sel.wr_hi};
        end
    end
endmodule : ram_pair_model
`default_nettype wire

// *** sim/tb_memory_map_decoder.sv ***
// Self-checking bench for the memory map decoder.
// Assumes the package and the RAM pair model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_memory_map_decoder;
    import memory_map_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    cpu_req_t req = '0;
    ram_size_t ram_size = RAM_8K;
    rom_size_t rom_size = ROM_16K;
    logic cfg_we = 1'b0;
    logic [7:0] cfg_size_kb = 8'h00;
    logic [1:0] cfg_waits = 2'h0;
    strobes_t strobes, st_a, st_b;
    mem_sel_t sel, sel_a;
    logic [16:0] rom_addr, ra_a;
    logic [15:0] io_addr, ia_a;
    logic [7:0] size_kb, lo_hits, hi_hits;
    logic [1:0] waits;
    logic ready;
    int err_total = 0;
    int checks_done = 0;
    int lat;
    always #10 clock = ~clock;
    memory_map_decoder i_dut (.clock, .reset, .req, .ram_size, .rom_size,
        .cfg_we, .cfg_size_kb, .cfg_waits, .strobes, .sel, .rom_addr,
        .io_addr, .size_kb, .waits, .ready);
    ram_pair_model i_ram (.clock, .strobes, .sel, .lo_hits, .hi_hits);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // One bus cycle, held until the edge that samples ready
    task automatic access(input logic [19:0] a, input logic [3:0] k);
        lat = 0;
        @(posedge clock);
        #1 req = {a, k};
        do begin
            @(posedge clock);
            #1 lat++;
        end while (ready !== 1'b1 && lat < 9);
        if (lat >= 9) begin
            err_total++;
            test_done();
        end
        // Ready is sampled at this edge; registered outputs then stand
        @(posedge clock);
        #1 st_a = strobes;
        sel_a = sel;
        ra_a = rom_addr;
        ia_a = io_addr;
        req = '0;
        // One cycle on, where the delayed I/O write shows
        @(posedge clock);
        #1 st_b = strobes;
    endtask : access
    task automatic set_cfg(input logic [7:0] kb, input logic [1:0] w);
        @(posedge clock);
        #1 {cfg_we, cfg_size_kb, cfg_waits} = {1'b1, kb, w};
        @(posedge clock);
        #1 cfg_we = 1'b0;
        check(size_kb, kb == 8'h00 ? 8'h01 : kb);
        check(waits, w);
    endtask : set_cfg
    task automatic t_ram();
        for (int s = 0; s < 3; s++) begin
            ram_size = ram_size_t'(s);
            for (int p = 0; p < 5; p++) begin
                if (s == 2 && p == 4) break;
                access(20'(p << (14 + 2 * s)) | 20'h00002, 4'h5);
                check(lat, 1);
                check(st_a, 4'h8);
                check(sel_a.ram_cs, p < 4 ? 4'(1 << p) : 4'h0);
            end
        end
        $display("pair select test done");
    endtask : t_ram
    task automatic t_rom();
        for (int w = 0; w < 4; w++) begin
            set_cfg(8'h00, 2'(w));
            rom_size = rom_size_t'(w);
            access(20'hFFC00, 4'h5);
            check(lat, 1 + w);
            check({sel_a.rom_cs, sel_a.ram_cs}, 5'h10);
            check(ra_a, 17'(20'h7FE00 & ((1 << (14 + w)) - 1)));
            access(20'hFFBFE, 4'h5);
            check({lat[1:0], sel_a.rom_cs}, 3'h2);
            // Writes into the window wait too and reach no RAM lane
            access(20'hFFC02, 4'h2);
            check(lat, 1 + w);
            check({sel_a.wr_lo, sel_a.wr_hi, sel_a.ram_cs}, 6'h00);
        end
        $display("window and wait test done");
    endtask : t_rom
    task automatic t_remap();
        ram_size = RAM_128K;
        set_cfg(8'h04, 2'h0);
        access(20'hFF000, 4'h5);
        check({sel_a.rom_cs, sel_a.ram_cs}, 5'h10);
        set_cfg(8'h01, 2'h0);
        access(20'hFF000, 4'h5);
        check({sel_a.rom_cs, sel_a.ram_cs}, 5'h08);
        $display("remap test done");
    endtask : t_remap
    task automatic t_bytes();
        for (int i = 0; i < 3; i++) begin
            access(20'h00002 + 20'(i), {3'h1, i == 0});
            check(st_a, 4'h4);
            check({sel_a.wr_lo, sel_a.wr_hi}, {i != 1, i != 0});
        end
        access(20'hFFFFE, 4'h3);
        check({lo_hits, hi_hits}, 16'h0202);
        $display("byte lane test done");
    endtask : t_bytes
    task automatic t_io();
        access(20'h1ABCD, 4'hD);
        check({st_a, ia_a}, 20'h2ABCD);
        access(20'h00010, 4'hB);
        check({lat[1:0], st_a, st_b}, 10'h101);
        $display("io test done");
    endtask : t_io
    initial begin
        repeat (6) @(posedge clock);
        #1 reset = 1'b0;
        check({size_kb, waits, strobes, sel, ready}, 22'h007000);
        t_ram();
        t_rom();
        t_remap();
        t_bytes();
        t_io();
        test_done();
    end
endmodule : tb_memory_map_decoder
`default_nettype wire
